// ### hw/voter_pkg.sv
// Shared constants, types and helpers for the trip voter
package voter_pkg;

  localparam int NUM_MON = 4;
  localparam int NUM_VOTER = 4;
  localparam int VOTERS_PER_SYS = 2;
  localparam int BYP_LINES = NUM_MON + 1;
  localparam int BYP_NONE_POS = NUM_MON;
  localparam int HEALTH_W = 2 * NUM_MON + BYP_LINES;
  localparam int GAP_W = 16;

  localparam int CLK_MHZ = 200;
  // Dynamic line half-period window and feedback toggle half-period
  localparam int MIN_GAP_NS = 500;
  localparam int MAX_GAP_NS = 50000;
  localparam int FB_HALF_NS = 5000;
  // Least time rounds up, longest time rounds down
  localparam int MIN_GAP_CYC = (MIN_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_GAP_CYC = (MAX_GAP_NS * CLK_MHZ) / 1000;
  localparam int FB_HALF_CYC = (FB_HALF_NS * CLK_MHZ) / 1000;
  localparam int FB_CNT_W = 12;

  localparam logic [2:0] VOTE_HALF_LEVEL = 3'h1;
  localparam logic [2:0] VOTE_FULL_LEVEL = 3'h2;
  localparam logic [2:0] BYP_ONE = 3'h1;

  typedef struct packed {
    logic power;
    logic osc;
  } trip_line_t;

  typedef struct packed {
    logic half_trip;
    logic full_trip;
    logic bypass_on;
    logic [NUM_MON-1:0] bypass_mask;
    logic selector_fault;
  } voter_stat_t;

  function automatic logic [2:0] ones4(input logic [NUM_MON-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < NUM_MON; i++)
    begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

endpackage

// ### hw/dyn_checker.sv
// Dynamic-encoding monitor for one incoming line
`timescale 1ns/1ps
`default_nettype none
module dyn_checker #(
  parameter int MIN_GAP = 100,
  parameter int MAX_GAP = 10000,
  parameter int GAP_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Line from outside the clock domain
  input wire logic line_in,
  // Line keeps toggling within the allowed window
  output logic alive
);

  localparam logic [GAP_W-1:0] MIN_L = GAP_W'(MIN_GAP - 1);
  localparam logic [GAP_W-1:0] MAX_L = GAP_W'(MAX_GAP);

  logic sync0_r;
  logic sync1_r;
  logic last_r;
  logic alive_r;
  logic alive_nxt;
  logic edge_seen;
  logic [GAP_W-1:0] gap_r;
  logic [GAP_W-1:0] gap_nxt;

  // Too-fast edges and stuck lines both drop alive; only a well-spaced edge raises it
  always_comb
  begin
    edge_seen = sync1_r ^ last_r;
    gap_nxt = gap_r;
    alive_nxt = alive_r;
    if (edge_seen)
    begin
      gap_nxt = '0;
      alive_nxt = (gap_r >= MIN_L);
    end
    else if (gap_r >= MAX_L)
    begin
      alive_nxt = 1'b0;
    end
    else
    begin
      gap_nxt = gap_r + 1'b1;
    end
  end

  // Gap starts saturated so the first good edge after reset is accepted
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync0_r <= 1'b0;
      sync1_r <= 1'b0;
      last_r <= 1'b0;
      gap_r <= MAX_L;
      alive_r <= 1'b0;
    end
    else
    begin
      sync0_r <= line_in;
      sync1_r <= sync0_r;
      last_r <= sync1_r;
      gap_r <= gap_nxt;
      alive_r <= alive_nxt;
    end
  end

  assign alive = alive_r;

endmodule
`default_nettype wire

// ### hw/trip_voter_with_channel_bypass.sv
// Four independent voter channels with single-channel bypass
//
// Behaviour
// - Bypass from one exclusive selector, at most one
// - Every voter checks inputs and bypass independently
// - Bypassed channel removed from both trip functions
// - With bypass, remaining three vote two-of-three
// - Only one monitor bypassable, voters never bypassable
// - Single trip gives half-trip, no trip outputs
// - Two trips give full trip in all voters
// - Dynamic inputs; two-of-four without bypass
// - Voters watch input dynamic encoding at all times
// - Voter outputs looped back to one monitor
`timescale 1ns/1ps
`default_nettype none
module trip_voter_with_channel_bypass #(
  parameter int MIN_GAP_CYCLES = voter_pkg::MIN_GAP_CYC,
  parameter int MAX_GAP_CYCLES = voter_pkg::MAX_GAP_CYC,
  parameter int FB_HALF_CYCLES = voter_pkg::FB_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Dynamic trip lines from the average_power_channel / oscillation_trip_channel units
  input wire voter_pkg::trip_line_t [voter_pkg::NUM_MON-1:0] mon_dyn,
  // Dynamic selector lines, top bit is the no-bypass position
  input wire logic [voter_pkg::BYP_LINES-1:0] byp_dyn,
  // Trip inputs to protection_trip_system A and B
  output wire logic [voter_pkg::VOTERS_PER_SYS-1:0] pts_a_trip,
  output wire logic [voter_pkg::VOTERS_PER_SYS-1:0] pts_b_trip,
  // Per-voter status and line health
  output wire voter_pkg::voter_stat_t [voter_pkg::NUM_VOTER-1:0] voter_stat,
  output wire logic [voter_pkg::NUM_VOTER-1:0][voter_pkg::HEALTH_W-1:0] line_ok,
  // Closed-loop feedback toward monitoring channel zero
  output wire logic [voter_pkg::NUM_VOTER-1:0] fb_dyn
);

  localparam int NM = voter_pkg::NUM_MON;
  localparam int NV = voter_pkg::NUM_VOTER;
  localparam int NB = voter_pkg::BYP_LINES;
  localparam int PER = voter_pkg::VOTERS_PER_SYS;
  localparam logic [voter_pkg::FB_CNT_W-1:0] FB_LAST =
    voter_pkg::FB_CNT_W'(FB_HALF_CYCLES - 1);

  logic [NV-1:0][NM-1:0] pwr_ok;
  logic [NV-1:0][NM-1:0] osc_ok;
  logic [NV-1:0][NB-1:0] byp_ok;
  logic [NV-1:0] full_trip;

  // Shared feedback rate divider; only paces the loopback toggle
  logic [voter_pkg::FB_CNT_W-1:0] fb_cnt_r;
  logic [voter_pkg::FB_CNT_W-1:0] fb_cnt_nxt;
  logic fb_en;

  always_comb
  begin
    fb_en = (fb_cnt_r == FB_LAST);
    fb_cnt_nxt = fb_en ? '0 : fb_cnt_r + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fb_cnt_r <= '0;
    end
    else
    begin
      fb_cnt_r <= fb_cnt_nxt;
    end
  end

  // Each voter owns its own checkers, so one bad synchroniser or checker
  // cannot bypass a channel in the other voters
  for (genvar v = 0; v < NV; v++)
  begin : g_voter
    logic [NM-1:0] ch_dead;
    logic [NM-1:0] byp_mask;
    logic [NM-1:0] votes;
    logic [2:0] vote_cnt;
    logic [2:0] byp_cnt;
    logic byp_valid;
    logic sel_fault;
    voter_pkg::voter_stat_t stat_r;
    voter_pkg::voter_stat_t stat_nxt;
    logic [voter_pkg::HEALTH_W-1:0] health_r;
    logic [voter_pkg::HEALTH_W-1:0] health_nxt;
    logic fb_r;
    logic fb_nxt;

    for (genvar m = 0; m < NM; m++)
    begin : g_mon
      dyn_checker #(
        .MIN_GAP(MIN_GAP_CYCLES),
        .MAX_GAP(MAX_GAP_CYCLES),
        .GAP_W(voter_pkg::GAP_W)
      ) u_pwr (
        .clk(clk),
        .srst(srst),
        .line_in(mon_dyn[m].power),
        .alive(pwr_ok[v][m])
      );

      dyn_checker #(
        .MIN_GAP(MIN_GAP_CYCLES),
        .MAX_GAP(MAX_GAP_CYCLES),
        .GAP_W(voter_pkg::GAP_W)
      ) u_osc (
        .clk(clk),
        .srst(srst),
        .line_in(mon_dyn[m].osc),
        .alive(osc_ok[v][m])
      );
    end

    for (genvar b = 0; b < NB; b++)
    begin : g_byp
      dyn_checker #(
        .MIN_GAP(MIN_GAP_CYCLES),
        .MAX_GAP(MAX_GAP_CYCLES),
        .GAP_W(voter_pkg::GAP_W)
      ) u_sel (
        .clk(clk),
        .srst(srst),
        .line_in(byp_dyn[b]),
        .alive(byp_ok[v][b])
      );
    end

    always_comb
    begin
      // Exactly one live position must be seen; anything else means no bypass
      byp_cnt = voter_pkg::ones4(byp_ok[v][NM-1:0]);
      byp_valid = (byp_cnt == voter_pkg::BYP_ONE) &&
                  !byp_ok[v][voter_pkg::BYP_NONE_POS];
      sel_fault = !(byp_valid ||
                    ((byp_cnt == 3'h0) && byp_ok[v][voter_pkg::BYP_NONE_POS]));
      byp_mask = byp_valid ? byp_ok[v][NM-1:0] : '0;
      // A quiet line is read as a trip, so loss of signal fails safe
      ch_dead = ~pwr_ok[v] | ~osc_ok[v];
      votes = ch_dead & ~byp_mask;
      vote_cnt = voter_pkg::ones4(votes);
      // Same threshold covers two-of-four and, with one masked, two-of-three
      stat_nxt.full_trip = (vote_cnt >= voter_pkg::VOTE_FULL_LEVEL);
      stat_nxt.half_trip = (vote_cnt == voter_pkg::VOTE_HALF_LEVEL);
      stat_nxt.bypass_on = byp_valid;
      stat_nxt.bypass_mask = byp_mask;
      stat_nxt.selector_fault = sel_fault;
      health_nxt = {byp_ok[v], osc_ok[v], pwr_ok[v]};
      // Loopback stops toggling once the voter trips, which the monitor detects
      fb_nxt = fb_r;
      if (fb_en && !stat_r.full_trip)
      begin
        fb_nxt = !fb_r;
      end
    end

    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        stat_r <= '0;
        health_r <= '0;
        fb_r <= 1'b0;
      end
      else
      begin
        stat_r <= stat_nxt;
        health_r <= health_nxt;
        fb_r <= fb_nxt;
      end
    end

    assign full_trip[v] = stat_r.full_trip;
    assign voter_stat[v] = stat_r;
    assign line_ok[v] = health_r;
    assign fb_dyn[v] = fb_r;
  end

  // Voters 0..1 feed system A, voters 2..3 feed system B; a half-trip drives neither
  assign pts_a_trip = full_trip[PER-1:0];
  assign pts_b_trip = full_trip[NV-1:PER];

endmodule
`default_nettype wire

// ### verification/trip_voter_assertions.sv
// Assertions on the trip voter ports
`timescale 1ns/1ps
`default_nettype none
module trip_voter_assertions #(
  parameter int MAX_GAP_CYCLES = voter_pkg::MAX_GAP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Watched ports
  input wire voter_pkg::trip_line_t [3:0] mon_dyn,
  input wire logic [1:0] pts_a_trip,
  input wire logic [1:0] pts_b_trip,
  input wire voter_pkg::voter_stat_t [3:0] voter_stat,
  input wire logic [3:0][12:0] line_ok,
  input wire logic [3:0] fb_dyn
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  wire voter_pkg::voter_stat_t v0 = voter_stat[0];
  // Cycles the channel 1 power line has stood still
  logic [15:0] still_r;
  logic last_r;
  always_ff @(posedge clk)
  begin
    last_r <= mon_dyn[1].power;
    still_r <= (srst || mon_dyn[1].power != last_r) ? 16'h0 :
      still_r + {15'h0, still_r != 16'hffff};
  end
  property p_pts_map;
    pts_a_trip == {voter_stat[1].full_trip, v0.full_trip} &&
      pts_b_trip == {voter_stat[3].full_trip, voter_stat[2].full_trip};
  endproperty
  a_pts_map: assert property (p_pts_map) else $error("pts map");
  property p_half_quiet;
    v0.half_trip |-> !v0.full_trip && pts_a_trip == 2'h0 && pts_b_trip == 2'h0;
  endproperty
  a_half_quiet: assert property (p_half_quiet) else $error("half");
  property p_one_byp;
    $onehot0(v0.bypass_mask);
  endproperty
  a_one_byp: assert property (p_one_byp) else $error("mask");
  property p_byp_flag;
    v0.bypass_on == (v0.bypass_mask != 4'h0);
  endproperty
  a_byp_flag: assert property (p_byp_flag) else $error("bypass flag");
  property p_fault;
    v0.selector_fault |-> v0.bypass_mask == 4'h0;
  endproperty
  a_fault: assert property (p_fault) else $error("fault");
  property p_agree;
    voter_stat[3] == v0;
  endproperty
  a_agree: assert property (p_agree) else $error("voters differ");
  property p_fb_hold;
    v0.full_trip [*3] |-> $stable(fb_dyn);
  endproperty
  a_fb_hold: assert property (p_fb_hold) else $error("fb moved");
  property p_dead;
    still_r > MAX_GAP_CYCLES + 6 && !v0.bypass_mask[1] |->
      !line_ok[0][1] && (v0.half_trip || v0.full_trip);
  endproperty
  a_dead: assert property (p_dead) else $error("dead line");
  c_half: cover property (v0.half_trip);
  c_full: cover property (v0.full_trip);
  c_byp: cover property (v0.bypass_on && v0.half_trip);
endmodule
bind trip_voter_with_channel_bypass trip_voter_assertions #(.MAX_GAP_CYCLES(MAX_GAP_CYCLES)) i_chk (
  .clk(clk), .srst(srst), .mon_dyn(mon_dyn), .pts_a_trip(pts_a_trip), .pts_b_trip(pts_b_trip),
  .voter_stat(voter_stat), .line_ok(line_ok), .fb_dyn(fb_dyn));
`default_nettype wire

// ### verification/mon_link_model.sv
// Monitoring channel and bypass selector line model
`timescale 1ns/1ps
`default_nettype none
module mon_link_model #(
  parameter int HALF = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Lines allowed to toggle, selector above channels
  input wire logic [12:0] run,
  // Dynamic lines toward the voters
  output wire logic [7:0] mon_dyn,
  output wire logic [4:0] byp_dyn
);
  logic [12:0] lines_r = 13'h0;
  int cnt = 0;
  assign mon_dyn = lines_r[7:0];
  assign byp_dyn = lines_r[12:8];
  // A frozen line is how a sender shows a trip
  always @(negedge clk)
  begin
    cnt <= (srst || cnt == HALF - 1) ? 0 : cnt + 1;
    if (!srst && cnt == HALF - 1)
      lines_r <= lines_r ^ run;
  end
endmodule
`default_nettype wire

// ### verification/trip_voter_with_channel_bypass_tb_top.sv
// Self-checking bench for the trip voter
`timescale 1ns/1ps
`default_nettype none
module trip_voter_with_channel_bypass_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [12:0] run = 13'h10ff;
  voter_pkg::trip_line_t [3:0] mon_dyn;
  logic [4:0] byp_dyn;
  logic [1:0] pts_a_trip;
  logic [1:0] pts_b_trip;
  voter_pkg::voter_stat_t [3:0] voter_stat;
  logic [3:0][12:0] line_ok;
  logic [3:0] fb_dyn;
  int err_count = 0;
  int cmp_count = 0;
  // Rows: running lines, then expected voter status
  logic [20:0] rows [7] = '{
    21'h10ff00,
    21'h10f780,
    21'h10e740,
    21'h02f724,
    21'h02f5a4,
    21'h02e564,
    21'h06f781};

  always #2.5 clk = ~clk;

  mon_link_model i_far (.clk(clk), .srst(srst), .run(run), .mon_dyn(mon_dyn), .byp_dyn(byp_dyn));
  trip_voter_with_channel_bypass #(.MIN_GAP_CYCLES(2), .MAX_GAP_CYCLES(20), .FB_HALF_CYCLES(4)) i_dut (
    .clk(clk), .srst(srst), .mon_dyn(mon_dyn), .byp_dyn(byp_dyn), .pts_a_trip(pts_a_trip),
    .pts_b_trip(pts_b_trip), .voter_stat(voter_stat), .line_ok(line_ok), .fb_dyn(fb_dyn));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic settle(input logic [7:0] exp);
    int k;
    for (k = 0; k < 100 && voter_stat[0] !== exp; k++)
      @(negedge clk);
    if (k == 100)
    begin
      check("settle", exp, voter_stat[0]);
      final_report();
    end
  endtask

  task automatic fb_moves(input logic exp);
    logic seen;
    logic [3:0] prev;
    seen = 1'b0;
    prev = fb_dyn;
    repeat (8)
    begin
      @(negedge clk);
      seen = seen | (fb_dyn !== prev);
      prev = fb_dyn;
    end
    check("fb moving", {7'h0, exp}, {7'h0, seen});
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    check("reset stat", 8'h00, voter_stat[0]);
    srst <= 1'b0;
    repeat (3) @(negedge clk);
    check("dead lines", 8'h40, voter_stat[0] & 8'h40);
    foreach (rows[i])
    begin
      run <= rows[i][20:8];
      settle(rows[i][7:0]);
      for (int v = 0; v < 4; v++)
        check("stat", rows[i][7:0], voter_stat[v]);
      check("pts", {4'h0, {4{rows[i][6]}}}, {4'h0, pts_a_trip, pts_b_trip});
    end
    fb_moves(1'b1);
    run <= 13'h1000;
    settle(8'h40);
    fb_moves(1'b0);
    srst <= 1'b1;
    repeat (3) @(negedge clk);
    check("second reset", 8'h00, {4'h0, pts_a_trip, pts_b_trip});
    final_report();
  end
endmodule
`default_nettype wire
